// *** core/pcc_pkg.sv ***
// Shared constants for the PWM counter control block
package pcc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W  = 12;
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned ADR_W  = 10;
  localparam int unsigned DAT_W  = 32;
  localparam int unsigned IDX_W  = 8;

  // ----------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_PERIOD_LOW  = 8'hD9;
  localparam logic [IDX_W-1:0] IDX_CTRL        = 8'hDC;
  localparam logic [IDX_W-1:0] IDX_CMP2_LOW    = 8'hDD;
  localparam logic [IDX_W-1:0] IDX_CMP6_LOW    = 8'hDE;
  localparam logic [IDX_W-1:0] IDX_BRAKE       = 8'hDF;
  localparam logic [IDX_W-1:0] IDX_PERIOD_HIGH = 8'hE8;
  localparam logic [IDX_W-1:0] IDX_CMP_BASE    = 8'hF0;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS  = 8'hF8;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR   = 8'hF9;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE  = 8'hFA;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_RUN_BIT   = 7;
  localparam int unsigned CTRL_LOAD_BIT  = 6;
  localparam int unsigned CTRL_FLAG_BIT  = 5;
  localparam int unsigned CTRL_CLEAR_BIT = 4;
  localparam int unsigned CTRL_INV_LSB   = 0;
  localparam int unsigned INV_W          = 4;

  // ----------------------------------------------------------------
  // Interrupt status layout
  // ----------------------------------------------------------------
  localparam int unsigned IRQ_MATCH_BIT = 0;
  localparam int unsigned IRQ_W         = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]       CTRL_RESET   = 8'h00;
  localparam logic [7:0]       BRAKE_RESET  = 8'h00;
  localparam logic [CNT_W-1:0] PERIOD_RESET = 12'h000;
  localparam logic [CNT_W-1:0] CMP_RESET    = 12'h000;
  localparam logic [IRQ_W-1:0] IRQ_RESET    = 1'h0;

endpackage : pcc_pkg

// *** core/pcc_wb_slave.sv ***
// Classic Wishbone slave handshake with one wait state
`timescale 1ns/1ps
module pcc_wb_slave
  import pcc_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Wishbone side
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  output logic                    wb_ack_o,
  output logic [pcc_pkg::DAT_W-1:0] wb_dat_o,
  // Register file side
  input  wire logic [pcc_pkg::DAT_W-1:0] rd_data_i,
  output logic                    wr_stb_o
);

  // ----------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------
  logic                 ack_r;
  logic [DAT_W-1:0]     dat_r;
  wire                  req_new = wb_cyc_i & wb_stb_i & ~ack_r;

  // Write lands on the edge where the master samples ack
  assign wr_stb_o = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= '0;
    end else begin
      ack_r <= req_new;
      // Read data frozen for the whole ack cycle
      if (req_new) begin
        dat_r <= rd_data_i;
      end
    end
  end

endmodule // pcc_wb_slave

// *** core/pcc_channel.sv ***
// One PWM channel output stage
`timescale 1ns/1ps
module pcc_channel
  import pcc_pkg::*;
#(
  parameter int unsigned W = pcc_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Compare inputs
  input  wire logic [W-1:0] count_i,
  input  wire logic [W-1:0] compare_i,
  input  wire logic         invert_i,
  // Brake override
  input  wire logic         brake_i,
  input  wire logic         brake_level_i,
  // Pin
  output logic              pwm_o
);

  // A zero-width compare has nothing to serve
  if (W < 1) begin : g_bad_w
    $error("pcc_channel: W must be at least 1");
  end

  logic out_r;
  // RULE_10 - counter below compare
  wire  raw   = (count_i < compare_i);
  // RULE_06 - polarity select
  wire  polar = raw ^ invert_i;
  // RULE_07 - brake level override
  wire  out_nxt = brake_i ? brake_level_i : polar;

  assign pwm_o = out_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_r <= 1'b0;
    end else begin
      out_r <= out_nxt;
    end
  end

endmodule // pcc_channel

// *** core/pcc_top.sv ***
// PWM counter control: shared counter, reload, flags and outputs
// Overview of operation
// RULE_01 - Run bit starts and stops the counter
// RULE_02 - Load bit reloads buffers at match
// RULE_03 - Load bit self-clears after the transfer
// RULE_04 - Match flag sticky until software clears
// RULE_05 - Clear bit zeroes counter, then self-clears
// RULE_06 - Invert bits set even channel polarity
// RULE_07 - Brake forces each output to level
// RULE_08 - Channel 2 and 6 low-byte compare registers
// RULE_09 - Writable low-byte period buffer register
// RULE_10 - Output compares counter with working value
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
module pcc_top
  import pcc_pkg::*;
#(
  parameter int unsigned CH = pcc_pkg::NUM_CH
) (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // Wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [pcc_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [pcc_pkg::DAT_W-1:0] wb_dat_i,
  output logic                           wb_ack_o,
  output logic [pcc_pkg::DAT_W-1:0]      wb_dat_o,
  // Brake input
  input  wire logic                      brake_i,
  // Outputs
  output logic [CH-1:0]                  pwm_o,
  output logic                           irq_o
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  // Register layout is fixed at eight channels
  if (CH != NUM_CH) begin : g_bad_ch
    $error("pcc_top: CH must be 8");
  end

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [IDX_W-1:0] idx);
    hit = (adr[ADR_W-1:2] == idx);
  endfunction

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic             wr_stb;
  logic [DAT_W-1:0] rd_data;

  pcc_wb_slave u_bus (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .wb_cyc_i  (wb_cyc_i),
    .wb_stb_i  (wb_stb_i),
    .wb_we_i   (wb_we_i),
    .wb_ack_o  (wb_ack_o),
    .wb_dat_o  (wb_dat_o),
    .rd_data_i (rd_data),
    .wr_stb_o  (wr_stb)
  );

  wire lane0 = wr_stb & wb_sel_i[0];
  wire lane1 = wr_stb & wb_sel_i[1];

  wire wr_ctrl     = lane0 & hit(wb_adr_i, IDX_CTRL);
  wire wr_per_lo   = lane0 & hit(wb_adr_i, IDX_PERIOD_LOW);
  wire wr_per_hi   = lane0 & hit(wb_adr_i, IDX_PERIOD_HIGH);
  wire wr_cmp2_lo  = lane0 & hit(wb_adr_i, IDX_CMP2_LOW);
  wire wr_cmp6_lo  = lane0 & hit(wb_adr_i, IDX_CMP6_LOW);
  wire wr_brake    = lane0 & hit(wb_adr_i, IDX_BRAKE);
  wire wr_irq_clr  = lane0 & hit(wb_adr_i, IDX_IRQ_CLEAR);
  wire wr_irq_en   = lane0 & hit(wb_adr_i, IDX_IRQ_ENABLE);
  wire cmp_region  = (wb_adr_i[ADR_W-1:5] == IDX_CMP_BASE[IDX_W-1:3]);
  wire [2:0] cmp_sel = wb_adr_i[4:2];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic             run_r;
  logic             load_r;
  logic             flag_r;
  logic [INV_W-1:0] inv_r;
  logic [7:0]       brake_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] per_buf_r;
  logic [CNT_W-1:0] per_w_r;
  logic [CNT_W-1:0] cmp_buf_r [CH];
  logic [CNT_W-1:0] cmp_w_r   [CH];
  logic [IRQ_W-1:0] sts_r;
  logic [IRQ_W-1:0] en_r;
  logic             irq_r;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // RULE_05 - clear on write of one
  wire clr_hit = wr_ctrl & wb_dat_i[CTRL_CLEAR_BIT];
  wire match   = run_r & (cnt_r == per_w_r);
  // RULE_02 - transfer only when requested
  wire xfer    = match & load_r;
  wire [CNT_W-1:0] cnt_inc = CNT_W'(cnt_r + 12'h001);
  // RULE_01 - count only while running
  wire [CNT_W-1:0] cnt_nxt = clr_hit ? '0 : (!run_r ? cnt_r : (match ? '0 : cnt_inc));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // RULE_03 - hardware clears load, new request wins
  wire load_nxt = wr_ctrl ? wb_dat_i[CTRL_LOAD_BIT] : (xfer ? 1'b0 : load_r);
  // RULE_04 - set wins over software clear
  wire flag_nxt = match | (wr_ctrl ? (flag_r & wb_dat_i[CTRL_FLAG_BIT]) : flag_r);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r  <= CTRL_RESET[CTRL_RUN_BIT];
      load_r <= CTRL_RESET[CTRL_LOAD_BIT];
      flag_r <= CTRL_RESET[CTRL_FLAG_BIT];
      inv_r  <= CTRL_RESET[CTRL_INV_LSB +: INV_W];
    end else begin
      load_r <= load_nxt;
      flag_r <= flag_nxt;
      if (wr_ctrl) begin
        run_r <= wb_dat_i[CTRL_RUN_BIT];
        inv_r <= wb_dat_i[CTRL_INV_LSB +: INV_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // Period and brake registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      per_buf_r <= PERIOD_RESET;
      per_w_r   <= PERIOD_RESET;
      brake_r   <= BRAKE_RESET;
    end else begin
      // RULE_09 - period low byte
      if (wr_per_lo) begin
        per_buf_r[7:0] <= wb_dat_i[7:0];
      end
      if (wr_per_hi) begin
        per_buf_r[CNT_W-1:8] <= wb_dat_i[CNT_W-9:0];
      end
      if (xfer) begin
        per_w_r <= per_buf_r;
      end
      if (wr_brake) begin
        brake_r <= wb_dat_i[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Compare buffers and channels
  // ----------------------------------------------------------------
  logic [CH-1:0] pwm_w;

  for (genvar n = 0; n < CH; n++) begin : g_ch
    // RULE_08 - low-byte aliases for 2 and 6
    wire alias_lo = ((n == 2) & wr_cmp2_lo) | ((n == 6) & wr_cmp6_lo);
    wire full_hit = cmp_region & (cmp_sel == 3'(n));
    // Odd channels have no invert control
    wire ch_inv   = (n % 2 == 0) ? inv_r[n/2] : 1'b0;

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cmp_buf_r[n] <= CMP_RESET;
        cmp_w_r[n]   <= CMP_RESET;
      end else begin
        if (alias_lo | (lane0 & full_hit)) begin
          cmp_buf_r[n][7:0] <= wb_dat_i[7:0];
        end
        if (lane1 & full_hit) begin
          cmp_buf_r[n][CNT_W-1:8] <= wb_dat_i[CNT_W-1:8];
        end
        // RULE_02 - compare transfer at match
        if (xfer) begin
          cmp_w_r[n] <= cmp_buf_r[n];
        end
      end
    end

    pcc_channel #(.W(CNT_W)) u_ch (
      .clk_i         (clk_i),
      .rst_i         (rst_i),
      .count_i       (cnt_r),
      .compare_i     (cmp_w_r[n]),
      .invert_i      (ch_inv),
      .brake_i       (brake_i),
      .brake_level_i (brake_r[n]),
      .pwm_o         (pwm_w[n])
    );
  end

  assign pwm_o = pwm_w;

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  wire [IRQ_W-1:0] evt     = match ? IRQ_W'(1) << IRQ_MATCH_BIT : '0;
  wire [IRQ_W-1:0] clr_msk = wr_irq_clr ? wb_dat_i[IRQ_W-1:0] : '0;
  // Set beats a clear in the same cycle
  wire [IRQ_W-1:0] sts_nxt = evt | (sts_r & ~clr_msk);
  wire [IRQ_W-1:0] en_nxt  = wr_irq_en ? wb_dat_i[IRQ_W-1:0] : en_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sts_r <= IRQ_RESET;
      en_r  <= IRQ_RESET;
      irq_r <= 1'b0;
    end else begin
      sts_r <= sts_nxt;
      en_r  <= en_nxt;
      irq_r <= |(sts_nxt & en_nxt);
    end
  end

  assign irq_o = irq_r;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Clear bit reads zero, it never holds state
  wire [7:0] ctrl_rd = {run_r, load_r, flag_r, 1'b0, inv_r};
  wire [CNT_W-1:0] cmp_rd = cmp_buf_r[cmp_sel];

  assign rd_data =
      hit(wb_adr_i, IDX_CTRL)        ? {24'h000000, ctrl_rd} :
      hit(wb_adr_i, IDX_PERIOD_LOW)  ? {24'h000000, per_buf_r[7:0]} :
      hit(wb_adr_i, IDX_PERIOD_HIGH) ? {28'h0000000, per_buf_r[CNT_W-1:8]} :
      hit(wb_adr_i, IDX_CMP2_LOW)    ? {24'h000000, cmp_buf_r[2][7:0]} :
      hit(wb_adr_i, IDX_CMP6_LOW)    ? {24'h000000, cmp_buf_r[6][7:0]} :
      hit(wb_adr_i, IDX_BRAKE)       ? {24'h000000, brake_r} :
      hit(wb_adr_i, IDX_IRQ_STATUS)  ? {31'h00000000, sts_r} :
      hit(wb_adr_i, IDX_IRQ_ENABLE)  ? {31'h00000000, en_r} :
      cmp_region                     ? {20'h00000, cmp_rd} :
                                       32'h00000000;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  run_hold_a: assert property ( // RULE_01
    !run_r && !clr_hit |=> cnt_r == $past(cnt_r))
    else $error("counter moved while stopped");

  run_count_a: assert property ( // RULE_01
    run_r && !match && !clr_hit |=> cnt_r == CNT_W'($past(cnt_r) + 12'h001))
    else $error("counter did not advance");

  load_xfer_a: assert property ( // RULE_02
    xfer |=> per_w_r == $past(per_buf_r) && cmp_w_r[2] == $past(cmp_buf_r[2]))
    else $error("reload did not transfer");

  no_load_a: assert property ( // RULE_02
    !load_r |=> $stable(per_w_r) && $stable(cmp_w_r[6]))
    else $error("working value changed without load");

  load_clear_a: assert property ( // RULE_03
    xfer && !wr_ctrl |=> !load_r)
    else $error("load bit not cleared after transfer");

  flag_set_a: assert property ( // RULE_04
    match |=> flag_r ##0 sts_r[IRQ_MATCH_BIT])
    else $error("match flag not set");

  flag_hold_a: assert property ( // RULE_04
    flag_r && !wr_ctrl |=> flag_r)
    else $error("match flag dropped by hardware");

  cnt_clear_a: assert property ( // RULE_05
    clr_hit |=> cnt_r == '0 ##1 ctrl_rd[CTRL_CLEAR_BIT] == 1'b0)
    else $error("counter clear failed");

  brake_out_a: assert property ( // RULE_07
    brake_i |=> pwm_o == $past(brake_r))
    else $error("brake level not driven");

  cmp2_low_a: assert property ( // RULE_08
    wr_cmp2_lo |=> cmp_buf_r[2][7:0] == $past(wb_dat_i[7:0]))
    else $error("channel 2 low byte not stored");

  period_low_a: assert property ( // RULE_09
    wr_per_lo |=> per_buf_r[7:0] == $past(wb_dat_i[7:0]))
    else $error("period low byte not stored");

  inv_out_a: assert property ( // RULE_06
    !brake_i |=> pwm_o[0] == (($past(cnt_r) < $past(cmp_w_r[0])) ^ $past(inv_r[0])))
    else $error("channel 0 polarity wrong");

  irq_level_a: assert property (
    irq_o == |(sts_r & en_r))
    else $error("interrupt level mismatch");

  reload_c: cover property (xfer ##1 !load_r);
  brake_c: cover property (brake_i ##1 brake_i);
  irq_c: cover property (match ##1 irq_o);
  clear_c: cover property (run_r && clr_hit);

endmodule // pcc_top

// *** verif/pcc_power_stage.sv ***
// Power stage model: on-time counters for every gate drive input
`timescale 1ns/1ps
module pcc_power_stage
  import pcc_pkg::*;
(
  // Clock and reset
  input  wire logic                               clk_i,
  input  wire logic                               rst_i,
  // Gate drives and measuring window
  input  wire logic [pcc_pkg::NUM_CH-1:0]         pwm_i,
  input  wire logic                               clr_i,
  input  wire logic                               win_i,
  // On-time per phase
  output logic      [pcc_pkg::NUM_CH-1:0][15:0]   on_cnt_o
);
  import pcc_pkg::*;

  // ----------------------------------------------------------------
  // On-time counting
  // ----------------------------------------------------------------
  // Whole periods only, so the phase of the window does not matter
  always_ff @(posedge clk_i) begin
    for (int n = 0; n < NUM_CH; n++) begin
      if (rst_i || clr_i) begin
        on_cnt_o[n] <= 16'h0000;
      end else if (win_i && pwm_i[n]) begin
        on_cnt_o[n] <= on_cnt_o[n] + 16'h0001;
      end
    end
  end
endmodule // pcc_power_stage

// *** verif/tb_pwm_counter_control.sv ***
// Self-checking bench for the PWM counter control block
`timescale 1ns/1ps
module tb_pwm_counter_control;
  import pcc_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                    clk_i = 1'b0;
  logic                    rst_i = 1'b1;
  logic                    cyc = 1'b0, stb = 1'b0, we = 1'b0, brake = 1'b0;
  logic [ADR_W-1:0]        adr = '0;
  logic [3:0]              sel = 4'h0;
  logic [DAT_W-1:0]        wdat = '0;
  logic                    ack, irq, clr = 1'b0, win = 1'b0;
  logic [DAT_W-1:0]        rdat;
  logic [NUM_CH-1:0]       pwm;
  logic [NUM_CH-1:0][15:0] on_cnt;
  int                      miscompares = 0;
  int                      compares = 0;

  always #10 clk_i = ~clk_i;

  pcc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
    .brake_i(brake), .pwm_o(pwm), .irq_o(irq));

  pcc_power_stage stage (.clk_i(clk_i), .rst_i(rst_i), .pwm_i(pwm), .clr_i(clr), .win_i(win),
    .on_cnt_o(on_cnt));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Request held until the rising edge that samples ack high
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; wdat <= d; sel <= 4'hF;
    for (k = 0; k < 100; k++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (k == 100) begin
      miscompares++;
      summarize();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 32'h0, q);
    chk(q, exp);
  endtask

  // Forty cycles, four whole periods of ten
  task automatic measure(input logic [NUM_CH-1:0][15:0] exp);
    @(posedge clk_i); clr <= 1'b1;
    @(posedge clk_i); clr <= 1'b0; win <= 1'b1;
    ticks(40); win <= 1'b0;
    ticks(2);
    for (int n = 0; n < NUM_CH; n++) chk({16'h0000, on_cnt[n]}, {16'h0000, exp[n]});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0][15:0] cmp, exp_on;

  task automatic t_reset_map();
    rd_chk(IDX_CTRL, 32'h0000_0000);
    rd_chk(IDX_BRAKE, 32'h0000_0000);
    rd_chk(IDX_IRQ_STATUS, 32'h0000_0000);
    rd_chk(8'h10, 32'h0000_0000);
  endtask

  task automatic t_no_load();
    for (int n = 0; n < NUM_CH; n++) wr(IDX_CMP_BASE + 8'(n), 32'h0000_0005);
    wr(IDX_CTRL, 32'h0000_0080);
    ticks(20);
    chk({24'h0, pwm}, 32'h0000_0000);
    rd_chk(IDX_CTRL, 32'h0000_00A0);
    wr(IDX_CTRL, 32'h0000_00A0);
    rd_chk(IDX_CTRL, 32'h0000_00A0);
  endtask

  task automatic t_load();
    for (int n = 0; n < NUM_CH; n++) begin
      cmp[n] = 16'(n + 1);
      wr(IDX_CMP_BASE + 8'(n), 32'(n + 1));
    end
    wr(IDX_PERIOD_LOW, 32'h0000_0009);
    wr(IDX_PERIOD_HIGH, 32'h0000_0000);
    wr(IDX_CMP2_LOW, 32'h0000_0005);
    wr(IDX_CMP6_LOW, 32'h0000_0003);
    cmp[2] = 16'h0005;
    cmp[6] = 16'h0003;
    rd_chk(IDX_CMP2_LOW, 32'h0000_0005);
    rd_chk(IDX_CMP6_LOW, 32'h0000_0003);
    wr(IDX_CTRL, 32'h0000_00C0);
    ticks(25);
    rd_chk(IDX_CTRL, 32'h0000_00A0);
    for (int n = 0; n < NUM_CH; n++) exp_on[n] = 16'(cmp[n] * 4);
    measure(exp_on);
  endtask

  task automatic t_invert();
    wr(IDX_CTRL, 32'h0000_008F);
    ticks(20);
    for (int n = 0; n < NUM_CH; n++) begin
      exp_on[n] = (n % 2 == 0) ? 16'((10 - cmp[n]) * 4) : 16'(cmp[n] * 4);
    end
    measure(exp_on);
  endtask

  task automatic t_brake();
    @(posedge clk_i); brake <= 1'b1;
    wr(IDX_BRAKE, 32'h0000_00A5);
    ticks(3);
    chk({24'h0, pwm}, 32'h0000_00A5);
    wr(IDX_BRAKE, 32'h0000_005A);
    ticks(3);
    chk({24'h0, pwm}, 32'h0000_005A);
    @(posedge clk_i); brake <= 1'b0;
  endtask

  task automatic t_stop_clear();
    logic [NUM_CH-1:0] held;
    wr(IDX_CTRL, 32'h0000_0000);
    ticks(3);
    held = pwm;
    ticks(20);
    chk({24'h0, pwm}, {24'h0, held});
    wr(IDX_CTRL, 32'h0000_0010);
    ticks(3);
    chk({24'h0, pwm}, 32'h0000_00FF);
    rd_chk(IDX_CTRL, 32'h0000_0000);
  endtask

  // Match status is set from the earlier runs
  task automatic t_irq();
    wr(IDX_IRQ_ENABLE, 32'h0000_0001);
    rd_chk(IDX_IRQ_STATUS, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(IDX_IRQ_STATUS, 32'h0000_0000);
    rd_chk(IDX_IRQ_STATUS, 32'h0000_0001);
    wr(IDX_IRQ_CLEAR, 32'h0000_0001);
    ticks(2);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(IDX_IRQ_ENABLE, 32'h0000_0000);
    wr(IDX_CTRL, 32'h0000_0080);
    ticks(30);
    rd_chk(IDX_IRQ_STATUS, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(IDX_IRQ_ENABLE, 32'h0000_0001);
    ticks(2);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(IDX_CTRL, 32'h0000_0000);
    wr(IDX_IRQ_CLEAR, 32'h0000_0001);
    ticks(2);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    ticks(6);
    rst_i <= 1'b0;
    t_reset_map();
    t_no_load();
    t_load();
    t_invert();
    t_brake();
    t_stop_clear();
    t_irq();
    summarize();
  end
endmodule // tb_pwm_counter_control
